// >>> hw/cvs_pkg.sv
// Purpose: shared constants, field positions and types for the convolver pin shell
// Assumes: one clock, synchronous active-high srst, host pins sampled on ref_clk
// Notes: host map is byte wide; multi-byte fields are little-endian
`default_nettype none

package cvs_pkg;
    // bus widths, shift stage count and buffer depth
    localparam int DATA_W = 8;
    localparam int CHAIN_W = 22;
    localparam int ADDR_W = 9;
    localparam int HOST_W = 8;
    localparam int SHIFT_STAGES = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int SHAMT_W = 4;

    // reset timing, in clock cycles
    localparam logic [1:0] RST_LOW_CYCLES = 2'h2;
    localparam logic [2:0] POR_CYCLES = 3'h4;

    // host map
    localparam logic [ADDR_W-1:0] ADDR_STATIC_CTRL = 9'h090;
    localparam logic [ADDR_W-1:0] ADDR_POST_CTRL = 9'h0A0;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_B0 = 9'h0B0;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_B1 = 9'h0B1;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_B2 = 9'h0B2;

    // static control fields and reset value
    localparam int SCR_BYPASS_BIT = 1;
    localparam int SCR_CHAIN_OE_BIT = 4;
    localparam int SCR_SHIFT_OE_BIT = 5;
    localparam logic [HOST_W-1:0] SCR_RESET = 8'h00;

    // post-processing control fields and reset value
    localparam int POST_SHAMT_LSB = 0;
    localparam int POST_LEFT_BIT = 4;
    localparam int POST_HALF_BIT = 5;
    localparam int POST_RECT_BIT = 6;
    localparam logic [HOST_W-1:0] POST_RESET = 8'h00;

    // host write commit sequencer
    typedef enum logic {
        WR_IDLE,
        WR_HOLD
    } cvs_wr_state_t;

    // state of the shell apart from the result buffer
    typedef struct packed {
        logic [1:0] rstLowCnt;
        logic [2:0] porCnt;
        logic [HOST_W-1:0] static_control_reg;
        logic [HOST_W-1:0] post;
        cvs_wr_state_t wrState;
        logic [1:0] wrSync;
        logic [HOST_W-1:0] rdData;
        logic [DATA_W-1:0] shiftIn;
        logic [SHIFT_STAGES-1:0][DATA_W-1:0] shiftStage;
        logic [DATA_W-1:0] shiftOut;
        logic [CHAIN_W-1:0] chainIn;
        logic [CHAIN_W-1:0] chainOut;
        logic chainOutVld;
    } cvs_state_t;
endpackage : cvs_pkg

`default_nettype wire

// >>> hw/cvs_shell.sv
// Purpose: pin shell of the convolver: shift path, cascade path, host port, reset
// Assumes: all pins synchronous to ref_clk; host holds addr/data while strobing
// Notes: three-state pins are split into value and enable; only the cascade pins are resolved, in the bench's neighbour model
// Functional notes
// - rounding adds half LSB then truncates
// - left shifts never add rounding increment
// - full-wave negates negative, keeps others
// - half-wave zeroes negative, keeps others
// - byte 0 lowest, bit 0 least significant
// - bypass gives exactly two-cycle shift latency
// - fully static, clock may stop anytime
// - pin low two cycles resets control
// - reset leaves datapath and shift contents
// - power-on reset ends after four cycles
// - shift input sampled each edge into chain
// - shift output is last chain stage
// - shift output floats until enable bit
// - cascade input captured each rising edge unless buffer full
// - cascade output driven from a register
// - cascade output floats until enable bit
// - access only with both enables low
// - enable high ignores strobe, floats data
// - write strobe low writes, high reads
// - host access allowed at any time
// - nine-bit address selects the location
// - write stores data, read drives contents
// - unmapped reads zero, unmapped writes dropped
`timescale 1ns/1ps
`default_nettype none

module cvs_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // fill side
    input wire logic wValid,
    output logic wReady,
    input wire logic [WIDTH-1:0] wData,
    // drain side
    output logic rValid,
    input wire logic rReady,
    output logic [WIDTH-1:0] rData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
    } cvs_fifo_state_t;

    cvs_fifo_state_t stQ;
    cvs_fifo_state_t stD;
    logic full;
    logic empty;

    // flags from pointer compare; extra bit tells full from empty
    assign empty = (stQ.wrPtr == stQ.rdPtr);
    assign full = (stQ.wrPtr[AW] != stQ.rdPtr[AW]) && (stQ.wrPtr[AW-1:0] == stQ.rdPtr[AW-1:0]);
    assign wReady = !full;
    assign rValid = !empty;
    assign rData = stQ.mem[stQ.rdPtr[AW-1:0]];

    // next state: push and pop may happen together
    always_comb
    begin
        stD = stQ;
        if (wValid && !full)
        begin
            stD.mem[stQ.wrPtr[AW-1:0]] = wData;
            stD.wrPtr = stQ.wrPtr + 1'b1;
        end
        if (rReady && !empty)
        begin
            stD.rdPtr = stQ.rdPtr + 1'b1;
        end
        if (srst)
        begin
            stD.wrPtr = '0;
            stD.rdPtr = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        stQ <= stD;
    end

    default clocking fifoCb @(posedge ref_clk); endclocking
    default disable iff (srst);

    fifo_no_overrun_a: assert property (full |=> stQ.wrPtr == $past(stQ.wrPtr))
        else $error("fifo pointer moved while full");
endmodule : cvs_fifo

module cvs_shell (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // device reset pin
    input wire logic resetPinN,
    // shift path
    input wire logic [cvs_pkg::DATA_W-1:0] shiftDataIn,
    output logic [cvs_pkg::DATA_W-1:0] shiftDataOut,
    output logic shiftDataOe,
    // cascade path
    input wire logic [cvs_pkg::CHAIN_W-1:0] chainDataIn,
    output logic chainInReady,
    output logic [cvs_pkg::CHAIN_W-1:0] chainDataOut,
    output logic chainDataOe,
    output logic chainOutValid,
    input wire logic chainOutReady,
    // host port
    input wire logic hostEnableAN,
    input wire logic hostEnableBN,
    input wire logic hostWriteN,
    input wire logic [cvs_pkg::ADDR_W-1:0] hostAddr,
    input wire logic [cvs_pkg::HOST_W-1:0] hostDataIn,
    output logic [cvs_pkg::HOST_W-1:0] hostDataOut,
    output logic hostDataOe
);
    import cvs_pkg::*;

    cvs_state_t stQ;
    cvs_state_t stD;
    logic ctlRst;
    logic hostSel;
    logic hostRd;
    logic hostWrReq;
    logic signed [CHAIN_W-1:0] localTerm;
    logic signed [CHAIN_W-1:0] scaled;
    logic signed [CHAIN_W-1:0] chainSum;
    logic [CHAIN_W-1:0] pushData;
    logic pushReady;
    logic fifoValid;
    logic [CHAIN_W-1:0] fifoData;
    logic popReady;

    // scale by a shift; only right shifts round, half LSB up then truncate
    function automatic logic signed [CHAIN_W-1:0] cvsScale(
        input logic signed [CHAIN_W-1:0] v,
        input logic [SHAMT_W-1:0] amt,
        input logic left
    );
        logic signed [CHAIN_W:0] ext;
        logic signed [CHAIN_W:0] shr;
        ext = {v[CHAIN_W-1], v};
        shr = ext;
        if (left)
        begin
            return v <<< amt;
        end
        if (amt != '0)
        begin
            ext = ext + ((CHAIN_W+1)'(1) <<< (amt - 1'b1));
            shr = ext >>> amt;
        end
        return shr[CHAIN_W-1:0];
    endfunction : cvsScale

    // remove negatives: full wave negates, half wave zeroes
    function automatic logic signed [CHAIN_W-1:0] cvsRectify(
        input logic signed [CHAIN_W-1:0] v,
        input logic en,
        input logic half
    );
        if (!en || !v[CHAIN_W-1])
        begin
            return v;
        end
        if (half)
        begin
            return '0;
        end
        return -v;
    endfunction : cvsRectify

    // defined host locations; anything else reads zero
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_STATIC_CTRL) || (a == ADDR_POST_CTRL) || (a == ADDR_RESULT_B0)
            || (a == ADDR_RESULT_B1) || (a == ADDR_RESULT_B2);
    endfunction : isMapped

    // host decode: both enables low opens the port
    assign hostSel = !hostEnableAN && !hostEnableBN;
    assign hostRd = hostSel && hostWriteN;
    assign hostWrReq = hostSel && !hostWriteN;
    assign hostDataOe = hostRd;
    assign hostDataOut = stQ.rdData;

    // control reset: srst, power-on window, or pin low for two samples
    assign ctlRst = srst || (stQ.porCnt < POR_CYCLES)
        || (!resetPinN && (stQ.rstLowCnt >= (RST_LOW_CYCLES - 2'h1)));

    // pins driven from registers; enables from static control
    assign shiftDataOut = stQ.shiftOut;
    assign shiftDataOe = stQ.static_control_reg[SCR_SHIFT_OE_BIT];
    assign chainDataOut = stQ.chainOut;
    assign chainDataOe = stQ.static_control_reg[SCR_CHAIN_OE_BIT];
    assign chainOutValid = stQ.chainOutVld;

    // local term: shift output widened, scaled, added to cascade, rectified
    assign localTerm = CHAIN_W'(signed'(stQ.shiftOut));
    assign scaled = cvsScale(localTerm, stQ.post[POST_SHAMT_LSB +: SHAMT_W],
        stQ.post[POST_LEFT_BIT]);
    assign chainSum = scaled + signed'(stQ.chainIn);
    assign pushData = cvsRectify(chainSum, stQ.post[POST_RECT_BIT], stQ.post[POST_HALF_BIT]);
    assign chainInReady = pushReady;
    assign popReady = chainOutReady || !stQ.chainOutVld;

    // result buffer between the adder and the cascade output register
    cvs_fifo #(
        .WIDTH(CHAIN_W),
        .DEPTH(FIFO_DEPTH)
    ) cvs_fifo_inst (
        .ref_clk(ref_clk),
        .srst(srst),
        .wValid(1'b1),
        .wReady(pushReady),
        .wData(pushData),
        .rValid(fifoValid),
        .rReady(popReady),
        .rData(fifoData)
    );

    // next state of the shell outside the result buffer; shift and cascade data fields never see reset
    always_comb
    begin
        stD = stQ;
        // power-on counter and pin-low counter
        if (stQ.porCnt < POR_CYCLES)
        begin
            stD.porCnt = stQ.porCnt + 3'h1;
        end
        if (resetPinN)
        begin
            stD.rstLowCnt = '0;
        end
        else if (stQ.rstLowCnt < RST_LOW_CYCLES)
        begin
            stD.rstLowCnt = stQ.rstLowCnt + 2'h1;
        end
        // shift chain: sampled every edge, three stages or bypass
        stD.shiftIn = shiftDataIn;
        stD.shiftStage[0] = stQ.shiftIn;
        for (int i = 1; i < SHIFT_STAGES; i++)
        begin
            stD.shiftStage[i] = stQ.shiftStage[i-1];
        end
        if (stQ.static_control_reg[SCR_BYPASS_BIT])
        begin
            stD.shiftOut = stQ.shiftIn;
        end
        else
        begin
            stD.shiftOut = stQ.shiftStage[SHIFT_STAGES-1];
        end
        // cascade input captured each edge unless the buffer is full
        if (pushReady)
        begin
            stD.chainIn = chainDataIn;
        end
        // cascade output register loads from the buffer head
        if (fifoValid && popReady)
        begin
            stD.chainOut = fifoData;
            stD.chainOutVld = 1'b1;
        end
        else if (chainOutReady)
        begin
            stD.chainOutVld = 1'b0;
        end
        // host read data, refreshed while a read is open
        if (hostRd)
        begin
            case (hostAddr)
                ADDR_STATIC_CTRL: stD.rdData = stQ.static_control_reg;
                ADDR_POST_CTRL: stD.rdData = stQ.post;
                ADDR_RESULT_B0: stD.rdData = stQ.chainOut[7:0];
                ADDR_RESULT_B1: stD.rdData = stQ.chainOut[15:8];
                ADDR_RESULT_B2: stD.rdData = {2'h0, stQ.chainOut[21:16]};
                default: stD.rdData = 8'h00;
            endcase
        end
        // write strobe through two flops before it may touch control
        stD.wrSync = {stQ.wrSync[0], hostWrReq};
        case (stQ.wrState)
            WR_IDLE:
            begin
                if (stQ.wrSync[1])
                begin
                    stD.wrState = WR_HOLD;
                    if (hostAddr == ADDR_STATIC_CTRL)
                    begin
                        stD.static_control_reg = hostDataIn;
                    end
                    else if (hostAddr == ADDR_POST_CTRL)
                    begin
                        stD.post = hostDataIn;
                    end
                end
            end
            WR_HOLD:
            begin
                if (!stQ.wrSync[1])
                begin
                    stD.wrState = WR_IDLE;
                end
            end
            default: stD.wrState = WR_IDLE;
        endcase
        // control reset touches control fields, read data and the cascade valid flag
        if (ctlRst)
        begin
            stD.static_control_reg = SCR_RESET;
            stD.post = POST_RESET;
            stD.wrState = WR_IDLE;
            stD.wrSync = '0;
            stD.rdData = 8'h00;
            stD.chainOutVld = 1'b0;
        end
        if (srst)
        begin
            stD.porCnt = '0;
            stD.rstLowCnt = '0;
        end
    end

    // state register; no gated clock, so a stopped clock only freezes it
    always_ff @(posedge ref_clk)
    begin
        stQ <= stD;
    end

    default clocking shellCb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence bypassHeld;
        stQ.static_control_reg[SCR_BYPASS_BIT] [*3];
    endsequence

    sequence pinLowTwice;
        !resetPinN ##1 !resetPinN;
    endsequence

    sequence porWindow;
        ctlRst [*4] ##1 (!ctlRst || !resetPinN);
    endsequence

    bypass_latency_a: assert property (
        bypassHeld |-> shiftDataOut == $past(shiftDataIn, 2))
        else $error("bypass latency is not two cycles");

    shift_float_a: assert property (
        ctlRst |=> !shiftDataOe)
        else $error("shift output enabled after reset");

    chain_float_a: assert property (
        ctlRst |=> !chainDataOe)
        else $error("cascade output enabled after reset");

    host_float_a: assert property (
        (hostEnableAN || hostEnableBN) |-> !hostDataOe)
        else $error("host data driven while disabled");

    host_read_a: assert property (
        (hostRd && hostAddr == ADDR_STATIC_CTRL && !ctlRst) |=> hostDataOut == $past(stQ.static_control_reg))
        else $error("host read of control returned wrong value");

    unmapped_zero_a: assert property (
        (hostRd && !isMapped(hostAddr)) |=> hostDataOut == 8'h00)
        else $error("unmapped read returned nonzero");

    reset_pin_a: assert property (
        pinLowTwice |=> (stQ.static_control_reg == SCR_RESET) && (stQ.post == POST_RESET))
        else $error("control not reset after pin low two cycles");

    power_on_a: assert property (
        ($fell(srst) && resetPinN) |-> porWindow)
        else $error("power-on reset window is not four cycles");

    write_sync_a: assert property (
        $rose(hostWrReq) |=> $stable(stQ.static_control_reg) [*2])
        else $error("host write reached control before synchronising");

    half_wave_a: assert property (
        (stQ.post[POST_RECT_BIT] && stQ.post[POST_HALF_BIT]) |-> !pushData[CHAIN_W-1])
        else $error("half-wave result is negative");
endmodule : cvs_shell

`default_nettype wire

// >>> verif/cvs_chain_sink.sv
// Purpose: downstream cascade neighbour of the convolver shell
// Assumes: stall is commanded by the bench to make the neighbour slow
// Notes: floating pins read back as the inverse of the last driven word
`timescale 1ns/1ps
`default_nettype none

module cvs_chain_sink (
    // clock
    input wire logic ref_clk,
    // cascade pins of the shell
    input wire logic [cvs_pkg::CHAIN_W-1:0] chainDataOut,
    input wire logic chainDataOe,
    input wire logic chainOutValid,
    output logic chainOutReady,
    // bench control
    input wire logic stall
);
    import cvs_pkg::*;
    logic [CHAIN_W-1:0] chainPins;
    logic [CHAIN_W-1:0] lastPin = 22'h000000;
    logic [CHAIN_W-1:0] got[$];

    // ready withheld while stalled
    assign chainOutReady = !stall;
    // released pins never show the last value
    assign chainPins = chainDataOe ? chainDataOut : ~lastPin;

    // take a word on each accepted edge
    always @(posedge ref_clk)
    begin
        if (chainDataOe)
            lastPin <= chainDataOut;
        if (chainOutValid && chainOutReady)
            got.push_back(chainPins);
    end
endmodule : cvs_chain_sink

`default_nettype wire

// >>> verif/cvs_shell_bench.sv
// Purpose: self-checking bench for the convolver pin shell
// Assumes: host pins driven on falling edges, held across the sampling edges
// Notes: cascade results are judged at the pins of the neighbour model
`timescale 1ns/1ps
`default_nettype none

module cvs_shell_bench;
    import cvs_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic resetPinN = 1'b1;
    logic [DATA_W-1:0] shiftDataIn = 8'h00;
    logic [DATA_W-1:0] shiftDataOut;
    logic shiftDataOe, chainInReady, chainDataOe, chainOutValid, chainOutReady, hostDataOe;
    logic [CHAIN_W-1:0] chainDataIn = 22'h000000;
    logic [CHAIN_W-1:0] chainDataOut;
    logic hostEnableAN = 1'b1;
    logic hostEnableBN = 1'b1;
    logic hostWriteN = 1'b1;
    logic [ADDR_W-1:0] hostAddr = 9'h000;
    logic [HOST_W-1:0] hostDataIn = 8'h00;
    logic [HOST_W-1:0] hostDataOut;
    logic stall = 1'b0;
    int errors = 0;
    int samplesChecked = 0;
    // post-processing cases: cascade in, shift in, post control, result
    logic [CHAIN_W-1:0] cinT[9] = '{22'h010000, 22'h000000, 22'h000000, 22'h000000,
        22'h000000, 22'h000000, 22'h000000, 22'h000000, 22'h000000};
    logic [7:0] sT[9] = '{8'h03, 8'h02, 8'hFE, 8'h01, 8'hFD, 8'h01, 8'hFB, 8'hFB, 8'h05};
    logic [7:0] pT[9] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h12, 8'h40, 8'h60, 8'h60};
    logic [CHAIN_W-1:0] eT[9] = '{22'h010001, 22'h000001, 22'h000000, 22'h000000,
        22'h3FFFFF, 22'h000004, 22'h000005, 22'h000000, 22'h000005};

    // 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    cvs_shell cvs_shell_inst (.ref_clk(ref_clk), .srst(srst), .resetPinN(resetPinN),
        .shiftDataIn(shiftDataIn), .shiftDataOut(shiftDataOut), .shiftDataOe(shiftDataOe),
        .chainDataIn(chainDataIn), .chainInReady(chainInReady),
        .chainDataOut(chainDataOut), .chainDataOe(chainDataOe),
        .chainOutValid(chainOutValid), .chainOutReady(chainOutReady),
        .hostEnableAN(hostEnableAN), .hostEnableBN(hostEnableBN), .hostWriteN(hostWriteN),
        .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe));

    cvs_chain_sink cvs_chain_sink_inst (.ref_clk(ref_clk), .chainDataOut(chainDataOut),
        .chainDataOe(chainDataOe), .chainOutValid(chainOutValid),
        .chainOutReady(chainOutReady), .stall(stall));

    task automatic chk_val(input string what, input logic [CHAIN_W-1:0] exp,
                           input logic [CHAIN_W-1:0] seen);
        samplesChecked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk_val

    task automatic chk_bit(input string what, input logic exp, input logic seen);
        samplesChecked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask : chk_bit

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // host write, strobe held four edges, two idle edges after
    task automatic host_wr(input logic [ADDR_W-1:0] a, input logic [HOST_W-1:0] d,
                           input logic enB);
        @(negedge ref_clk);
        hostEnableAN = 1'b0;
        hostEnableBN = enB;
        hostWriteN = 1'b0;
        hostAddr = a;
        hostDataIn = d;
        repeat (4) @(negedge ref_clk);
        hostEnableAN = 1'b1;
        hostEnableBN = 1'b1;
        hostWriteN = 1'b1;
        hostDataIn = ~d;
        repeat (2) @(negedge ref_clk);
    endtask : host_wr

    // host read of one location
    task automatic host_rd(input logic [ADDR_W-1:0] a, input logic [HOST_W-1:0] exp);
        @(negedge ref_clk);
        hostEnableAN = 1'b0;
        hostEnableBN = 1'b0;
        hostWriteN = 1'b1;
        hostAddr = a;
        hostDataIn = ~hostDataIn;
        #1 chk_bit("read drive", 1'b1, hostDataOe);
        repeat (2) @(negedge ref_clk);
        chk_val("read data", {14'h0000, exp}, {14'h0000, hostDataOut});
        hostEnableAN = 1'b1;
        hostEnableBN = 1'b1;
        #1 chk_bit("idle float", 1'b0, hostDataOe);
    endtask : host_rd

    task automatic test_reset_state;
        chk_bit("shift enable", 1'b0, shiftDataOe);
        chk_bit("cascade enable", 1'b0, chainDataOe);
        host_rd(ADDR_STATIC_CTRL, SCR_RESET);
        host_rd(ADDR_POST_CTRL, POST_RESET);
        host_wr(ADDR_STATIC_CTRL, 8'h32, 1'b0);
        chk_bit("shift enable", 1'b1, shiftDataOe);
        chk_bit("cascade enable", 1'b1, chainDataOe);
        host_rd(ADDR_STATIC_CTRL, 8'h32);
        $display("reset state and control write done");
    endtask : test_reset_state

    task automatic test_bypass;
        logic [7:0] v[12];
        int lat;
        // full chain first (five edges), then bypass (two edges)
        for (int m = 0; m < 2; m++)
        begin
            lat = (m == 0) ? 5 : 2;
            host_wr(ADDR_STATIC_CTRL, (m == 0) ? 8'h30 : 8'h32, 1'b0);
            for (int i = 0; i < 12; i++)
            begin
                @(negedge ref_clk);
                if (i >= lat)
                    chk_val("shift output", {14'h0, v[i-lat]},
                        {14'h0, shiftDataOut});
                v[i] = 8'hA0 + 8'(i);
                shiftDataIn = v[i];
            end
        end
        $display("shift latency done");
    endtask : test_bypass

    task automatic test_enables;
        host_wr(ADDR_STATIC_CTRL, 8'h00, 1'b1);
        @(negedge ref_clk);
        hostEnableAN = 1'b0;
        #1 chk_bit("half enabled float", 1'b0, hostDataOe);
        hostEnableAN = 1'b1;
        host_rd(ADDR_STATIC_CTRL, 8'h32);
        host_wr(9'h0A1, 8'hFF, 1'b0);
        host_rd(9'h0A1, 8'h00);
        host_rd(ADDR_POST_CTRL, POST_RESET);
        host_rd(9'h1FF, 8'h00);
        $display("enables and unmapped done");
    endtask : test_enables

    task automatic test_post;
        for (int i = 0; i < 9; i++)
        begin
            @(negedge ref_clk);
            chainDataIn = cinT[i];
            shiftDataIn = sT[i];
            host_wr(ADDR_POST_CTRL, pT[i], 1'b0);
            repeat (12) @(negedge ref_clk);
            chk_val("result", eT[i], cvs_chain_sink_inst.chainPins);
            host_rd(ADDR_RESULT_B0, eT[i][7:0]);
            host_rd(ADDR_RESULT_B1, eT[i][15:8]);
            host_rd(ADDR_RESULT_B2, {2'b00, eT[i][21:16]});
        end
        $display("post processing done");
    endtask : test_post

    task automatic test_fifo;
        logic [CHAIN_W-1:0] q[$];
        logic [CHAIN_W-1:0] lastIn;
        logic took, sawFull, bad;
        host_wr(ADDR_POST_CTRL, 8'h00, 1'b0);
        shiftDataIn = 8'h00;
        chainDataIn = 22'h000100;
        lastIn = 22'h000100;
        repeat (10) @(negedge ref_clk);
        cvs_chain_sink_inst.got.delete();
        stall = 1'b1;
        took = 1'b0;
        sawFull = 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            @(negedge ref_clk);
            if (took && i < 30)
                chainDataIn = chainDataIn + 22'h000001;
            if (i == 20)
                stall = 1'b0;
            if (chainInReady !== 1'b1)
                sawFull = 1'b1;
            took = (chainInReady === 1'b1);
            if (took && i < 30)
                lastIn = chainDataIn;
        end
        q = cvs_chain_sink_inst.got;
        bad = (q.size() == 0);
        for (int k = 1; k < q.size(); k++)
            if (q[k] !== q[k-1] + 22'h1
                && !(q[k] === q[k-1] && (q[k] == 22'h100 || q[k] == lastIn)))
                bad = 1'b1;
        chk_bit("input refused when full", 1'b1, sawFull);
        chk_bit("cascade order broken", 1'b0, bad);
        if (q.size() > 0)
            chk_val("last cascade word", lastIn, q[q.size()-1]);
        $display("cascade buffering done");
    endtask : test_fifo

    task automatic test_reset_pin;
        @(negedge ref_clk);
        shiftDataIn = 8'h5A;
        resetPinN = 1'b0;
        @(negedge ref_clk);
        resetPinN = 1'b1;
        host_rd(ADDR_STATIC_CTRL, 8'h32);
        @(negedge ref_clk);
        resetPinN = 1'b0;
        repeat (2) @(negedge ref_clk);
        resetPinN = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_bit("shift enable", 1'b0, shiftDataOe);
        chk_bit("cascade enable", 1'b0, chainDataOe);
        chk_val("shift kept", 22'h00005A, {14'h0, shiftDataOut});
        host_rd(ADDR_STATIC_CTRL, SCR_RESET);
        $display("reset pin done");
    endtask : test_reset_pin

    // watchdog against a hang
    initial
    begin
        #1000000;
        errors++;
        end_sim();
    end

    // main sequence
    initial
    begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        repeat (6) @(negedge ref_clk);
        test_reset_state();
        test_bypass();
        test_enables();
        test_post();
        test_fifo();
        test_reset_pin();
        end_sim();
    end
endmodule : cvs_shell_bench

`default_nettype wire
